// >>> transceiver_loopback_select.sv
/*
 * per-channel loopback routing for a two-channel serial transceiver,
 * with prbs-7 source and checker, and an axi4-lite register slave.
 * assumes the deserialized receive words already arrive on sys_clk and
 * that the analog section obeys the routing and power controls below.
 */
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module transceiver_loopback_select
	import loop_select_pkg::*;
(
	input  wire logic                        sys_clk,
	input  wire logic                        reset,
	// selectors and configuration straps
	input  wire logic [SEL_W-1:0]            chan0_loop_select,
	input  wire logic [SEL_W-1:0]            chan1_loop_select,
	input  wire logic [DIV_W-1:0]            tx_clock_divider_setting,
	input  wire logic [NCH-1:0]              tx_buffer_enable,
	// user side
	input  wire logic [NCH-1:0][WORD_W-1:0]  user_tx_data,
	output logic      [NCH-1:0][WORD_W-1:0]  user_rx_data,
	// serial section side
	input  wire logic [NCH-1:0][WORD_W-1:0]  ser_rx_data,
	output logic      [NCH-1:0][WORD_W-1:0]  ser_tx_data,
	output logic      [NCH-1:0]              line_drive_en,
	output logic      [NCH-1:0]              pma_power_down,
	output logic      [NCH-1:0]              pma_serial_loop,
	output logic      [NCH-1:0]              tx_clk_use_recovered,
	output logic      [NCH-1:0]              tx_buffer_route,
	output logic                             irq,
	// axi4-lite slave
	input  wire logic [ADDR_W-1:0]           s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [DATA_W-1:0]           s_axi_wdata,
	input  wire logic [DATA_W/8-1:0]         s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [ADDR_W-1:0]           s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [DATA_W-1:0]                s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready
);
	import loop_select_pkg::*;

	////////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		logic [NCH-1:0][SEL_W-1:0]  sel_prev;
		logic [NCH-1:0][SEL_W-1:0]  mode;
		logic [NCH-1:0][WORD_W-1:0] gen;
		logic [NCH-1:0][WORD_W-1:0] rx_prev;
		logic [NCH-1:0][WORD_W-1:0] rx_user;
		logic [NCH-1:0][WORD_W-1:0] ser_tx;
		logic [NCH-1:0][CNT_W-1:0]  err_cnt;
		logic [NCH-1:0]             cfg_bad;
		logic [NCH-1:0]             line_en;
		logic [NCH-1:0]             pma_pd;
		logic [NCH-1:0]             serial_loop;
		logic [NCH-1:0]             rclk;
		logic [NCH-1:0]             txbuf;
		logic [NCH-1:0]             prbs_sel;
		logic [IRQ_W-1:0]           irq_stat;
		logic [IRQ_W-1:0]           irq_mask;
		logic                       aw_have;
		logic                       w_have;
		logic [ADDR_W-1:0]          aw_addr;
		logic [DATA_W-1:0]          w_data;
		logic [DATA_W/8-1:0]        w_strb;
		logic                       bvalid;
		logic [1:0]                 bresp;
		logic                       rvalid;
		logic [DATA_W-1:0]          rdata;
		logic [1:0]                 rresp;
	} state_t;

	state_t             st_r;
	state_t             st_nxt;
	logic [SYNC_W-1:0]  pins_sync;
	logic [NCH-1:0][SEL_W-1:0] sel_s;
	logic [DIV_W-1:0]   div_s;
	logic [NCH-1:0]     bufen_s;

	////////////////////////////////////////////////////////////////////
	// functions
	function automatic logic [WORD_W-1:0] prbs_next(
		input logic [WORD_W-1:0] word
	);
		logic [6:0]        s;
		logic [WORD_W-1:0] o;
		logic              b;
		s = word[6:0];
		o = '0;
		for (int i = WORD_W - 1; i >= 0; i--) begin
			b    = s[6] ^ s[5];
			s    = {s[5:0], b};
			o[i] = b;
		end
		return o;
	endfunction : prbs_next

	function automatic logic [DATA_W-1:0] strb_merge(
		input logic [DATA_W-1:0]   old_v,
		input logic [DATA_W-1:0]   new_v,
		input logic [DATA_W/8-1:0] strb
	);
		logic [DATA_W-1:0] r;
		r = old_v;
		for (int i = 0; i < DATA_W / 8; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction : strb_merge

	function automatic logic addr_known(input logic [ADDR_W-1:0] a);
		return (a == OFS_CTRL) || (a == OFS_STATUS) ||
			(a == OFS_IRQ_STAT) || (a == OFS_IRQ_MASK) ||
			(a == OFS_ERRCNT0) || (a == OFS_ERRCNT1);
	endfunction : addr_known

	function automatic logic is_reserved(input logic [SEL_W-1:0] c);
		return (c == SEL_RSV_3) || (c == SEL_RSV_5) || (c == SEL_RSV_7);
	endfunction : is_reserved

	////////////////////////////////////////////////////////////////////
	// pin synchronisation
	pin_sync u_pin_sync (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.async_in ({tx_buffer_enable, tx_clock_divider_setting,
			chan1_loop_select, chan0_loop_select}),
		.sync_out (pins_sync)
	);

	assign sel_s[0] = pins_sync[SEL_W-1:0];
	assign sel_s[1] = pins_sync[2*SEL_W-1:SEL_W];
	assign div_s    = pins_sync[2*SEL_W+DIV_W-1:2*SEL_W];
	assign bufen_s  = pins_sync[SYNC_W-1:2*SEL_W+DIV_W];

	////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		logic [IRQ_W-1:0]          ev;
		logic [IRQ_W-1:0]          clr;
		logic [NCH-1:0][WORD_W-1:0] tx_src;
		logic [NCH-1:0][WORD_W-1:0] rx_chk;
		logic [DATA_W-1:0]         rd;
		logic                      aw_h;
		logic                      w_h;
		ev     = '0;
		clr    = '0;
		tx_src = '0;
		rx_chk = '0;
		rd     = '0;
		aw_h   = 1'b0;
		w_h    = 1'b0;
		st_nxt = st_r;

		// routing per channel
		for (int c = 0; c < NCH; c++) begin
			st_nxt.sel_prev[c] = sel_s[c];
			if (sel_s[c] != st_r.sel_prev[c]) begin
				ev[IRQ_CHANGE + c] = 1'b1;
			end
			if (is_reserved(sel_s[c])) begin
				ev[IRQ_RSV + c]  = 1'b1;
				st_nxt.mode[c]   = SEL_NORMAL;
			end else begin
				st_nxt.mode[c]   = sel_s[c];
			end

			if (st_r.prbs_sel[c]) begin
				st_nxt.gen[c] = prbs_next(st_r.gen[c]);
			end
			tx_src[c] = st_r.prbs_sel[c] ? st_r.gen[c] : user_tx_data[c];

			st_nxt.line_en[c]     = 1'b1;
			st_nxt.pma_pd[c]      = 1'b0;
			st_nxt.serial_loop[c] = 1'b0;
			st_nxt.rclk[c]        = 1'b0;
			st_nxt.txbuf[c]       = 1'b0;
			st_nxt.cfg_bad[c]     = 1'b0;
			case (st_r.mode[c])
				SEL_NORMAL: begin
					st_nxt.ser_tx[c]  = tx_src[c];
					st_nxt.rx_user[c] = ser_rx_data[c];
				end
				SEL_NEAR_PCS: begin
					st_nxt.ser_tx[c]  = '0;
					st_nxt.rx_user[c] = tx_src[c];
					st_nxt.line_en[c] = 1'b0;
					st_nxt.pma_pd[c]  = 1'b1;
				end
				SEL_NEAR_PMA: begin
					st_nxt.ser_tx[c]      = tx_src[c];
					st_nxt.serial_loop[c] = 1'b1;
					st_nxt.rx_user[c]     = ser_rx_data[c];
				end
				SEL_FAR_PMA: begin
					st_nxt.ser_tx[c]  = ser_rx_data[c];
					st_nxt.rx_user[c] = '0;
					st_nxt.rclk[c]    = 1'b1;
					st_nxt.txbuf[c]   = 1'b1;
					st_nxt.cfg_bad[c] = (div_s != TX_DIV_FAR_PMA) ||
						!bufen_s[c];
				end
				SEL_FAR_PCS: begin
					st_nxt.ser_tx[c]  = ser_rx_data[c];
					st_nxt.rx_user[c] = ser_rx_data[c];
				end
				default: begin
					st_nxt.ser_tx[c]  = tx_src[c];
					st_nxt.rx_user[c] = ser_rx_data[c];
				end
			endcase
			if (st_nxt.cfg_bad[c] && !st_r.cfg_bad[c]) begin
				ev[IRQ_CFG + c] = 1'b1;
			end

			// self-synchronising prbs check on looped-in words
			rx_chk[c]         = st_r.rx_user[c];
			st_nxt.rx_prev[c] = rx_chk[c];
			if (st_r.prbs_sel[c] && (st_r.mode[c] != SEL_FAR_PMA) &&
				(st_r.mode[c] != SEL_FAR_PCS) &&
				(rx_chk[c] != prbs_next(st_r.rx_prev[c]))) begin
				ev[IRQ_PRBS + c] = 1'b1;
				if (st_r.err_cnt[c] != '1) begin
					st_nxt.err_cnt[c] = st_r.err_cnt[c] + 1'b1;
				end
			end
		end

		// axi write: address and data in either order
		aw_h = st_r.aw_have;
		w_h  = st_r.w_have;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_h           = 1'b1;
			st_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_h           = 1'b1;
			st_nxt.w_data = s_axi_wdata;
			st_nxt.w_strb = s_axi_wstrb;
		end
		st_nxt.aw_have = aw_h;
		st_nxt.w_have  = w_h;
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (aw_h && w_h && !st_r.bvalid) begin
			st_nxt.aw_have = 1'b0;
			st_nxt.w_have  = 1'b0;
			st_nxt.bvalid  = 1'b1;
			st_nxt.bresp   = addr_known(st_nxt.aw_addr) ?
				RESP_OKAY : RESP_SLVERR;
			case (st_nxt.aw_addr)
				OFS_CTRL: begin
					st_nxt.prbs_sel = NCH'(strb_merge(
						{{(DATA_W-NCH){1'b0}}, st_r.prbs_sel},
						st_nxt.w_data, st_nxt.w_strb));
				end
				OFS_IRQ_STAT: begin
					clr = IRQ_W'(strb_merge('0, st_nxt.w_data,
						st_nxt.w_strb));
				end
				OFS_IRQ_MASK: begin
					st_nxt.irq_mask = IRQ_W'(strb_merge(
						{{(DATA_W-IRQ_W){1'b0}}, st_r.irq_mask},
						st_nxt.w_data, st_nxt.w_strb));
				end
				default: begin
					clr = '0;
				end
			endcase
		end
		// set wins over a simultaneous write-one clear
		st_nxt.irq_stat = (st_r.irq_stat & ~clr) | ev;

		// axi read
		if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !st_r.rvalid) begin
			case (s_axi_araddr)
				OFS_CTRL:     rd[NCH-1:0] = st_r.prbs_sel;
				OFS_STATUS: begin
					rd[STATUS_MODE0 +: SEL_W] = st_r.mode[0];
					rd[STATUS_MODE1 +: SEL_W] = st_r.mode[1];
					rd[STATUS_BAD +: NCH]     = st_r.cfg_bad;
				end
				OFS_IRQ_STAT: rd[IRQ_W-1:0] = st_r.irq_stat;
				OFS_IRQ_MASK: rd[IRQ_W-1:0] = st_r.irq_mask;
				OFS_ERRCNT0:  rd[CNT_W-1:0] = st_r.err_cnt[0];
				OFS_ERRCNT1:  rd[CNT_W-1:0] = st_r.err_cnt[1];
				default:      rd = '0;
			endcase
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata  = rd;
			st_nxt.rresp  = addr_known(s_axi_araddr) ?
				RESP_OKAY : RESP_SLVERR;
		end
	end

	////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st_r          <= '0;
			st_r.gen      <= {NCH{{(WORD_W-7){1'b0}}, PRBS_SEED}};
			st_r.prbs_sel <= CTRL_RST;
			st_r.irq_mask <= IRQ_MASK_RST;
			st_r.pma_pd   <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs
	assign user_rx_data         = st_r.rx_user;
	assign ser_tx_data          = st_r.ser_tx;
	assign line_drive_en        = st_r.line_en;
	assign pma_power_down       = st_r.pma_pd;
	assign pma_serial_loop      = st_r.serial_loop;
	assign tx_clk_use_recovered = st_r.rclk;
	assign tx_buffer_route      = st_r.txbuf;
	assign irq                  = |(st_r.irq_stat & st_r.irq_mask);

	assign s_axi_awready = !st_r.aw_have && !st_r.bvalid;
	assign s_axi_wready  = !st_r.w_have && !st_r.bvalid;
	assign s_axi_bvalid  = st_r.bvalid;
	assign s_axi_bresp   = st_r.bresp;
	assign s_axi_arready = !st_r.rvalid;
	assign s_axi_rvalid  = st_r.rvalid;
	assign s_axi_rdata   = st_r.rdata;
	assign s_axi_rresp   = st_r.rresp;

endmodule : transceiver_loopback_select
`default_nettype wire

// >>> loop_select_pkg.sv
/*
 * shared constants for the two-channel loopback selector: selector codes,
 * datapath widths, register offsets, field positions and reset values.
 * assumes a 125 mhz system clock and a 32-bit axi4-lite register bus.
 */
`default_nettype none
package loop_select_pkg;

	localparam int unsigned NCH    = 2;
	localparam int unsigned SEL_W  = 3;
	localparam int unsigned WORD_W = 20;
	localparam int unsigned CNT_W  = 16;
	localparam int unsigned DIV_W  = 2;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned IRQ_W  = 8;
	localparam int unsigned SYNC_W = NCH * SEL_W + DIV_W + NCH;

	// selector codes
	localparam logic [SEL_W-1:0] SEL_NORMAL   = 3'h0;
	localparam logic [SEL_W-1:0] SEL_NEAR_PCS = 3'h1;
	localparam logic [SEL_W-1:0] SEL_NEAR_PMA = 3'h2;
	localparam logic [SEL_W-1:0] SEL_RSV_3    = 3'h3;
	localparam logic [SEL_W-1:0] SEL_FAR_PMA  = 3'h4;
	localparam logic [SEL_W-1:0] SEL_RSV_5    = 3'h5;
	localparam logic [SEL_W-1:0] SEL_FAR_PCS  = 3'h6;
	localparam logic [SEL_W-1:0] SEL_RSV_7    = 3'h7;

	// far-end serial loop needs the transmit divider at one
	localparam logic [DIV_W-1:0] TX_DIV_FAR_PMA = 2'h1;
	// recovered clock tracking range, parts per million
	localparam int unsigned      CDR_TRACK_PPM  = 1000;

	// prbs-7 generator seed after reset
	localparam logic [6:0]        PRBS_SEED = 7'h7f;
	localparam logic [SYNC_W-1:0] SYNC_RST  = 10'h000;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_ERRCNT0  = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_ERRCNT1  = 8'h14;

	// field positions
	localparam int unsigned STATUS_MODE0 = 0;
	localparam int unsigned STATUS_MODE1 = 3;
	localparam int unsigned STATUS_BAD   = 6;
	localparam int unsigned IRQ_CHANGE   = 0;
	localparam int unsigned IRQ_RSV      = 2;
	localparam int unsigned IRQ_PRBS     = 4;
	localparam int unsigned IRQ_CFG      = 6;

	// reset values
	localparam logic [NCH-1:0]   CTRL_RST     = 2'h0;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 8'h00;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : loop_select_pkg
`default_nettype wire

// >>> pin_sync.sv
/*
 * two-stage synchroniser for a bundle of asynchronous levels.
 * assumes the inputs are quasi-static levels; no multi-bit coherence.
 */
`timescale 1ns/10ps
`default_nettype none
module pin_sync
	import loop_select_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              reset,
	input  wire logic [SYNC_W-1:0] async_in,
	output logic      [SYNC_W-1:0] sync_out
);
	import loop_select_pkg::*;

	typedef struct packed {
		logic [SYNC_W-1:0] meta;
		logic [SYNC_W-1:0] stable;
	} sync_state_t;

	sync_state_t st_r;
	sync_state_t st_nxt;

	always_comb begin
		st_nxt        = st_r;
		st_nxt.meta   = async_in;
		st_nxt.stable = st_r.meta;
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st_r <= '{meta: SYNC_RST, stable: SYNC_RST};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sync_out = st_r.stable;

endmodule : pin_sync
`default_nettype wire

// >>> loop_select_chk.sv
/* port assertions for channel 0 routing and the register bus handshake.
   assumes the block clocks everything on sys_clk with reset high. */
`timescale 1ns/10ps
`default_nettype none
module loop_select_chk
	import loop_select_pkg::*;
(
	input wire logic                       sys_clk,
	input wire logic                       reset,
	input wire logic [SEL_W-1:0]           chan0_loop_select,
	input wire logic [NCH-1:0][WORD_W-1:0] user_rx_data,
	input wire logic [NCH-1:0][WORD_W-1:0] ser_rx_data,
	input wire logic [NCH-1:0][WORD_W-1:0] ser_tx_data,
	input wire logic [NCH-1:0]             line_drive_en,
	input wire logic [NCH-1:0]             pma_power_down,
	input wire logic [NCH-1:0]             pma_serial_loop,
	input wire logic [NCH-1:0]             tx_clk_use_recovered,
	input wire logic [NCH-1:0]             tx_buffer_route,
	input wire logic                       s_axi_awvalid,
	input wire logic                       s_axi_awready,
	input wire logic                       s_axi_wvalid,
	input wire logic                       s_axi_wready,
	input wire logic                       s_axi_bvalid,
	input wire logic                       s_axi_arvalid,
	input wire logic                       s_axi_arready,
	input wire logic                       s_axi_rvalid
);
	import loop_select_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////////
	property p_near_par; pma_power_down[0] |->
		!line_drive_en[0] && ser_tx_data[0] == '0; endproperty
	a_near_par: assert property (p_near_par) else $error("near parallel");
	property p_near_ser; pma_serial_loop[0] |->
		line_drive_en[0] && !pma_power_down[0]; endproperty
	a_near_ser: assert property (p_near_ser) else $error("near serial");
	property p_far_ser; tx_clk_use_recovered[0] |->
		tx_buffer_route[0] && user_rx_data[0] == '0; endproperty
	a_far_ser: assert property (p_far_ser) else $error("far serial");
	property p_far_echo; tx_clk_use_recovered[0] && $past(tx_clk_use_recovered[0])
		|-> ser_tx_data[0] == $past(ser_rx_data[0]); endproperty
	a_far_echo: assert property (p_far_echo) else $error("far echo");
	property p_one_mode; $onehot0({pma_power_down[0], pma_serial_loop[0],
		tx_clk_use_recovered[0]}); endproperty
	a_one_mode: assert property (p_one_mode) else $error("two modes");
	property p_sync; $changed(chan0_loop_select) |=> $stable({pma_power_down[0],
		pma_serial_loop[0], tx_clk_use_recovered[0]})[*3]; endproperty
	a_sync: assert property (p_sync) else $error("routing too early");
	property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> s_axi_bvalid; endproperty
	a_wr: assert property (p_wr) else $error("no write response");
	property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd: assert property (p_rd) else $error("no read response");
	property p_rbusy; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_rbusy: assert property (p_rbusy) else $error("read taken while busy");
endmodule : loop_select_chk
bind transceiver_loopback_select loop_select_chk loop_select_chk_i (
	.sys_clk, .reset, .chan0_loop_select, .user_rx_data, .ser_rx_data,
	.ser_tx_data, .line_drive_en, .pma_power_down, .pma_serial_loop,
	.tx_clk_use_recovered, .tx_buffer_route, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid);
`default_nettype wire

// >>> link_partner_model.sv
/* far link partner: sends a new word each cycle, or echoes what it gets.
   assumes received words move once per sys_clk edge. */
`timescale 1ns/10ps
`default_nettype none
module link_partner_model
	import loop_select_pkg::*;
(
	input  wire logic                       sys_clk,
	input  wire logic                       reset,
	input  wire logic                       echo,
	input  wire logic [NCH-1:0][WORD_W-1:0] ser_tx_data,
	output var  logic [NCH-1:0][WORD_W-1:0] ser_rx_data
);
	// plain data code groups only, no clock correction characters
	always @(posedge sys_clk or posedge reset) begin
		if (reset)
			ser_rx_data <= '0;
		else if (echo)
			ser_rx_data <= ser_tx_data;
		else
			ser_rx_data <= 40'({$urandom, $urandom});
	end
endmodule : link_partner_model
`default_nettype wire

// >>> transceiver_loopback_select_bench.sv
/* self-checking bench: routing per code, status, irq, prbs loop, registers.
   assumes the far side is link_partner_model and axi reads are queued. */
`timescale 1ns/10ps
`default_nettype none
module transceiver_loopback_select_bench;
	import loop_select_pkg::*;
	typedef struct packed {logic [1:0] resp; logic [31:0] data;} rd_exp_t;
	logic                       sys_clk, reset, irq, echo;
	logic [SEL_W-1:0]           chan0_loop_select, chan1_loop_select;
	logic [DIV_W-1:0]           tx_clock_divider_setting;
	logic [NCH-1:0]             tx_buffer_enable, line_drive_en;
	logic [NCH-1:0]             pma_power_down, pma_serial_loop;
	logic [NCH-1:0]             tx_clk_use_recovered, tx_buffer_route;
	logic [NCH-1:0][WORD_W-1:0] user_tx_data, user_rx_data, u_p, s_p;
	logic [NCH-1:0][WORD_W-1:0] ser_rx_data, ser_tx_data;
	logic [ADDR_W-1:0]          s_axi_awaddr, s_axi_araddr;
	logic [DATA_W-1:0]          s_axi_wdata, s_axi_rdata;
	logic [3:0]                 s_axi_wstrb;
	logic [1:0]                 s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	int errors, total_checks;
	rd_exp_t rq[$];
	rd_exp_t re;
	logic [3:0] flag_tab [8] = '{4'h0, 4'h8, 4'h4, 4'h0, 4'h3, 4'h0, 4'h0, 4'h0};
	int tx_tab [8] = '{1, 0, 1, 1, 2, 1, 2, 1};
	int rx_tab [8] = '{2, 1, 2, 2, 0, 2, 2, 2};
	////////////////////////////////////////////////////////////////////
	transceiver_loopback_select transceiver_loopback_select_i (.sys_clk,
		.reset, .chan0_loop_select, .chan1_loop_select,
		.tx_clock_divider_setting, .tx_buffer_enable, .user_tx_data,
		.user_rx_data, .ser_rx_data, .ser_tx_data, .line_drive_en,
		.pma_power_down, .pma_serial_loop, .tx_clk_use_recovered,
		.tx_buffer_route, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	link_partner_model link_partner_model_i (.sys_clk, .reset, .echo,
		.ser_tx_data, .ser_rx_data);
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		u_p = user_tx_data;
		s_p = ser_rx_data;
		user_tx_data <= 40'({$urandom, $urandom});
	end
	always @(negedge sys_clk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			re = rq.pop_front();
			chk("rresp", re.resp, s_axi_rresp);
			chk("rdata", re.data, s_axi_rdata);
		end
	end
	////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic irq_chk(input logic e);
		@(negedge sys_clk);
		chk("irq", e, irq);
	endtask : irq_chk
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test
	task automatic wait_hi(input int w);
		int n;
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (!(w == 0 ? s_axi_arready : w == 1 ? s_axi_rvalid
			: s_axi_bvalid) && n < 50);
		if (n >= 50) begin
			chk("handshake", 1, 0);
			finish_test();
		end
	endtask : wait_hi
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int n;
		logic pa, pw;
		pa = 1'b1;
		pw = 1'b1;
		n = 0;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while ((pa || pw) && n < 50) begin
			@(negedge sys_clk);
			if (s_axi_awready === 1'b1) pa = 1'b0;
			if (s_axi_wready === 1'b1) pw = 1'b0;
			@(posedge sys_clk);
			if (!pa) s_axi_awvalid <= 1'b0;
			if (!pw) s_axi_wvalid <= 1'b0;
			n++;
		end
		if (pa || pw) begin
			chk("handshake", 1, 0);
			finish_test();
		end
		wait_hi(2);
		chk("bresp", er, s_axi_bresp);
		@(posedge sys_clk);
		s_axi_bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, input logic [1:0] er,
		input logic [31:0] ed);
		rq.push_back('{er, ed});
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		wait_hi(0);
		@(posedge sys_clk);
		s_axi_arvalid <= 1'b0;
		wait_hi(1);
		@(posedge sys_clk);
		s_axi_rready <= 1'b0;
	endtask : axi_rd
	function automatic logic [WORD_W-1:0] pick(input int k,
		input logic [WORD_W-1:0] u, s);
		return k == 0 ? '0 : k == 1 ? u : s;
	endfunction : pick
	function automatic logic [2:0] md(input logic [2:0] k);
		return (k[0] && k != 3'h1) ? 3'h0 : k;
	endfunction : md
	task automatic set_sel(input logic [2:0] a, b);
		@(posedge sys_clk);
		chan0_loop_select <= a;
		chan1_loop_select <= b;
		repeat (8) @(posedge sys_clk);
	endtask : set_sel
	task automatic route_chk(input int i, input int k);
		chk("flags", flag_tab[k], {pma_power_down[i], pma_serial_loop[i],
			tx_clk_use_recovered[i], tx_buffer_route[i]});
		chk("ser_tx", pick(tx_tab[k], u_p[i], s_p[i]), ser_tx_data[i]);
		chk("user_rx", pick(rx_tab[k], u_p[i], s_p[i]), user_rx_data[i]);
		if (k != 4 && k != 6) chk("line_en", k != 1, line_drive_en[i]);
	endtask : route_chk
	////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(1));
		errors = 0;
		total_checks = 0;
		reset = 1'b1;
		echo = 1'b0;
		chan0_loop_select = '0;
		chan1_loop_select = '0;
		tx_clock_divider_setting = TX_DIV_FAR_PMA;
		tx_buffer_enable = 2'h3;
		user_tx_data = '0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hf;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		repeat (4) @(posedge sys_clk);
		reset <= 1'b0;
		axi_rd(OFS_CTRL, RESP_OKAY, 32'h0);
		axi_rd(OFS_IRQ_MASK, RESP_OKAY, 32'h0);
		axi_rd(8'h20, RESP_SLVERR, 32'h0);
		axi_wr(8'h20, 32'hffffffff, RESP_SLVERR);
		axi_wr(OFS_IRQ_MASK, 32'h5a, RESP_OKAY);
		axi_rd(OFS_IRQ_MASK, RESP_OKAY, 32'h5a);
		axi_wr(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
		$display("test registers done");
		for (int c = 0; c < 8; c++) begin
			set_sel(c[2:0], 3'h7 - c[2:0]);
			repeat (2) begin
				@(negedge sys_clk);
				route_chk(0, c);
				route_chk(1, 7 - c);
			end
			axi_rd(OFS_STATUS, RESP_OKAY, {md(3'h7 - c[2:0]), md(c[2:0])});
		end
		$display("test modes done");
		tx_clock_divider_setting <= 2'h0;
		set_sel(SEL_FAR_PMA, SEL_NORMAL);
		axi_rd(OFS_STATUS, RESP_OKAY, 32'h44);
		tx_clock_divider_setting <= TX_DIV_FAR_PMA;
		tx_buffer_enable <= 2'h2;
		set_sel(SEL_FAR_PMA, SEL_NORMAL);
		axi_rd(OFS_STATUS, RESP_OKAY, 32'h44);
		tx_buffer_enable <= 2'h3;
		set_sel(SEL_NORMAL, SEL_NORMAL);
		$display("test config done");
		axi_wr(OFS_IRQ_MASK, 32'h1, RESP_OKAY);
		axi_wr(OFS_IRQ_STAT, 32'hff, RESP_OKAY);
		irq_chk(1'b0);
		set_sel(SEL_NEAR_PMA, SEL_NORMAL);
		irq_chk(1'b1);
		axi_wr(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
		irq_chk(1'b0);
		axi_wr(OFS_IRQ_MASK, 32'h1, RESP_OKAY);
		irq_chk(1'b1);
		axi_wr(OFS_IRQ_STAT, 32'h1, RESP_OKAY);
		irq_chk(1'b0);
		$display("test irq done");
		axi_wr(OFS_CTRL, 32'h1, RESP_OKAY);
		axi_rd(OFS_CTRL, RESP_OKAY, 32'h1);
		echo <= 1'b1;
		repeat (20) @(posedge sys_clk);
		axi_rd(OFS_IRQ_STAT, RESP_OKAY, 32'h10);
		axi_rd(OFS_ERRCNT1, RESP_OKAY, 32'h0);
		axi_wr(OFS_IRQ_STAT, 32'hff, RESP_OKAY);
		repeat (20) @(posedge sys_clk);
		axi_rd(OFS_IRQ_STAT, RESP_OKAY, 32'h0);
		axi_wr(OFS_STATUS, 32'hff, RESP_OKAY);
		axi_rd(OFS_STATUS, RESP_OKAY, 32'h2);
		$display("test prbs done");
		repeat (4) @(posedge sys_clk);
		chk("reads left", 0, rq.size());
		finish_test();
	end
endmodule : transceiver_loopback_select_bench
`default_nettype wire
